//--- hw/dav_pkg.sv
package dav_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int DAV_SAMPLE_W = 16; // raw sensor word from the signal chain
   localparam int DAV_TERM_W = 17; // sample plus predecessor
   localparam int DAV_ACC_W = 34; // room for 65536 terms of 17 bits
   localparam int DAV_GAIN_W = 16; // unsigned scale factor
   localparam int DAV_PROD_W = 51; // acc times zero-extended gain
   localparam int DAV_RESULT_W = 32; // combined output word
   localparam int DAV_WORD_W = 16; // one register
   localparam int DAV_ADDR_W = 7; // register address
   localparam int DAV_DEC_W = 16; // decimation setting
   localparam int DAV_CHANNELS = 6; // three angle, three speed
   localparam int DAV_AXES = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int DAV_CLK_HZ = 10_000_000; // clk_in rate
   localparam int DAV_SAMPLE_RATE_SPS = 2000; // nominal internal sample rate
   localparam int DAV_SAMPLE_CYCLES = DAV_CLK_HZ / DAV_SAMPLE_RATE_SPS;

   // ----------------------------------------------------------------
   // scaling: result = (sum of sample pairs * gain) >>> shift
   // ----------------------------------------------------------------
   localparam int DAV_SCALE_SHIFT = 16; // folds in 1/(2*fs) and unit scale
   localparam logic [DAV_GAIN_W-1:0] DAV_GAIN_360 = 16'h1000; // plain default
   localparam logic [DAV_GAIN_W-1:0] DAV_GAIN_720 = 16'h0800; // half of 360
   localparam logic [DAV_GAIN_W-1:0] DAV_GAIN_2160 = 16'h02AB; // sixth of 360
   localparam logic [DAV_GAIN_W-1:0] DAV_GAIN_SPEED = 16'h1000; // +-100 m/s span
   localparam logic [DAV_RESULT_W-1:0] DAV_POS_MAX = 32'h7FFFFFFF;
   localparam logic [DAV_RESULT_W-1:0] DAV_NEG_MAX = 32'h80000000;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [DAV_ADDR_W-1:0] DAV_X_ANGLE_STEP_LOW = 7'h24;
   localparam logic [DAV_ADDR_W-1:0] DAV_X_ANGLE_STEP_HIGH = 7'h26;
   localparam logic [DAV_ADDR_W-1:0] DAV_Y_ANGLE_STEP_LOW = 7'h28;
   localparam logic [DAV_ADDR_W-1:0] DAV_Y_ANGLE_STEP_HIGH = 7'h2A;
   localparam logic [DAV_ADDR_W-1:0] DAV_Z_ANGLE_STEP_LOW = 7'h2C;
   localparam logic [DAV_ADDR_W-1:0] DAV_Z_ANGLE_STEP_HIGH = 7'h2E;
   localparam logic [DAV_ADDR_W-1:0] DAV_X_SPEED_STEP_LOW = 7'h30;
   localparam logic [DAV_ADDR_W-1:0] DAV_X_SPEED_STEP_HIGH = 7'h32;
   localparam logic [DAV_ADDR_W-1:0] DAV_Y_SPEED_STEP_LOW = 7'h34;
   localparam logic [DAV_ADDR_W-1:0] DAV_Y_SPEED_STEP_HIGH = 7'h36;
   localparam logic [DAV_ADDR_W-1:0] DAV_Z_SPEED_STEP_LOW = 7'h38;
   localparam logic [DAV_ADDR_W-1:0] DAV_Z_SPEED_STEP_HIGH = 7'h3A;
   localparam logic [DAV_WORD_W-1:0] DAV_UNMAPPED = 16'h0000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {DAV_RANGE_360, DAV_RANGE_720, DAV_RANGE_2160} dav_range_t;

   typedef struct packed {
      logic signed [DAV_SAMPLE_W-1:0] x;
      logic signed [DAV_SAMPLE_W-1:0] y;
      logic signed [DAV_SAMPLE_W-1:0] z;
   } dav_sensor_t;

   typedef struct packed {
      logic signed [DAV_RESULT_W-1:0] x;
      logic signed [DAV_RESULT_W-1:0] y;
      logic signed [DAV_RESULT_W-1:0] z;
   } dav_triple_t;

   typedef struct packed {
      dav_triple_t angle;
      dav_triple_t speed;
   } dav_frame_t;

endpackage : dav_pkg

//--- hw/dav_integ.sv
module dav_integ (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sample_valid_in,
   input wire logic first_in,
   input wire logic last_in,
   input wire logic signed [dav_pkg::DAV_SAMPLE_W-1:0] sample_in,
   input wire logic [dav_pkg::DAV_GAIN_W-1:0] gain_in,
   output logic signed [dav_pkg::DAV_RESULT_W-1:0] result_out,
   output logic done_out
);
   import dav_pkg::*;

   // ----------------------------------------------------------------
   // trapezoid term and running sum
   // ----------------------------------------------------------------
   logic signed [DAV_SAMPLE_W-1:0] prev; // predecessor sample, kept across intervals
   logic signed [DAV_ACC_W-1:0] acc; // sum of terms within the interval
   logic signed [DAV_TERM_W-1:0] term; // sample plus predecessor
   logic signed [DAV_ACC_W-1:0] next_acc;
   logic signed [DAV_PROD_W-1:0] product; // sum scaled by gain
   logic signed [DAV_PROD_W-1:0] scaled;
   logic [DAV_PROD_W-DAV_RESULT_W:0] top_bits; // must all match for no overflow

   // the first term of an interval pairs with the last sample of the one before
   always_comb begin
      term = DAV_TERM_W'(sample_in) + DAV_TERM_W'(prev);
      next_acc = first_in ? DAV_ACC_W'(term) : acc + DAV_ACC_W'(term);
      product = DAV_PROD_W'(next_acc) * $signed({1'b0, gain_in});
      scaled = product >>> DAV_SCALE_SHIFT;
      top_bits = scaled[DAV_PROD_W-1:DAV_RESULT_W-1];
   end

   // accumulator and predecessor
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc <= '0;
         prev <= '0;
      end else if (sample_valid_in) begin
         acc <= next_acc;
         prev <= sample_in;
      end
   end

   // result latches at the end of the interval, saturated rather than wrapped
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         result_out <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= sample_valid_in && last_in;
         if (sample_valid_in && last_in) begin
            if (&top_bits || ~|top_bits) begin
               result_out <= scaled[DAV_RESULT_W-1:0];
            end else if (scaled[DAV_PROD_W-1]) begin
               result_out <= DAV_NEG_MAX;
            end else begin
               result_out <= DAV_POS_MAX;
            end
         end
      end
   end

endmodule : dav_integ

//--- hw/dav_buf2.sv
module dav_buf2 #(
   parameter int WIDTH = 192
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);

   // ----------------------------------------------------------------
   // two-entry store
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] slot [2]; // storage
   logic wr_ptr; // next slot to fill
   logic rd_ptr; // slot shown on the output
   logic [1:0] count; // entries held
   logic push;
   logic pop;

   assign in_ready_out = (count != 2'h2); // full refuses the writer
   assign out_valid_out = (count != 2'h0); // empty shows nothing
   assign out_data_out = slot[rd_ptr]; // straight from the flops
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // slot contents change only on a push
   always_ff @(posedge clk_in) begin
      if (push) begin
         slot[wr_ptr] <= in_data_in;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : dav_buf2

//--- hw/dav_outputs.sv
// Operation
// - each angle axis split low and high word
// - high word: zero is zero, span over 2^15
// - sixteen-bit extremes read 7FFF and 8000
// - thirty-two-bit result saturates to signed extremes
// - trapezoid sum scaled by half sample period
// - interval length is decimation setting plus one
// - internal sample tick at nominal 2000 per second
// - velocity change computed for all three axes
// - speed high word spans plus minus 100
// - speed low word extends resolution to 32 bits
// - two speed registers per axis, same layout
// - angle scale follows gyroscope range option
module dav_outputs #(
   parameter int SAMPLE_CYCLES = dav_pkg::DAV_SAMPLE_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire dav_pkg::dav_sensor_t gyro_in,
   input wire dav_pkg::dav_sensor_t accel_in,
   input wire logic [1:0] gyro_range_in,
   input wire logic [dav_pkg::DAV_DEC_W-1:0] decimation_setting_in,
   input wire logic reg_rd_in,
   input wire logic [dav_pkg::DAV_ADDR_W-1:0] reg_addr_in,
   output logic [dav_pkg::DAV_WORD_W-1:0] reg_data_out,
   output logic reg_ack_out,
   output logic sample_tick_out,
   output logic update_out,
   output logic result_room_out
);
   import dav_pkg::*;

   // ----------------------------------------------------------------
   // internal sample clock
   // ----------------------------------------------------------------
   localparam int TICK_W = $clog2(SAMPLE_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);

   logic [TICK_W-1:0] tick_count; // cycles into the current sample period
   logic sample_tick; // one cycle per sample

   // divider from clk_in down to the nominal sample rate; the rate is only
   // as good as clk_in, which is why the host may measure and rescale
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tick_count <= '0;
      end else if (tick_count == TICK_LAST) begin
         tick_count <= '0;
      end else begin
         tick_count <= tick_count + 1'b1;
      end
   end

   assign sample_tick = (tick_count == TICK_LAST);

   // tick is exported so that the rate can be observed from outside
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sample_tick_out <= 1'b0;
      end else begin
         sample_tick_out <= sample_tick;
      end
   end

   // ----------------------------------------------------------------
   // decimation interval
   // ----------------------------------------------------------------
   logic [DAV_DEC_W-1:0] sample_index; // samples taken in this interval
   logic interval_first; // this sample opens an interval
   logic interval_last; // this sample closes an interval

   // a setting lowered to or below sample_index closes the interval at the next sample
   assign interval_first = (sample_index == '0);
   assign interval_last = (sample_index >= decimation_setting_in);

   // counts D = setting + 1 samples per output update
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sample_index <= '0;
      end else if (sample_tick) begin
         if (interval_last) begin
            sample_index <= '0;
         end else begin
            sample_index <= sample_index + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // range option
   // ----------------------------------------------------------------
   dav_range_t gyro_range; // decoded option
   logic [DAV_GAIN_W-1:0] angle_gain; // gain for the three angle channels

   // the unused code falls back to the narrowest range
   always_comb begin
      unique case (gyro_range_in)
         2'h1: gyro_range = DAV_RANGE_720;
         2'h2: gyro_range = DAV_RANGE_2160;
         default: gyro_range = DAV_RANGE_360;
      endcase
   end

   // scale factor picks the full-scale angle for one LSB
   always_comb begin
      unique case (gyro_range)
         DAV_RANGE_360: angle_gain = DAV_GAIN_360;
         DAV_RANGE_720: angle_gain = DAV_GAIN_720;
         DAV_RANGE_2160: angle_gain = DAV_GAIN_2160;
      endcase
   end

   // ----------------------------------------------------------------
   // six integrators
   // ----------------------------------------------------------------
   logic signed [DAV_SAMPLE_W-1:0] ch_sample [DAV_CHANNELS]; // per-channel input
   logic [DAV_GAIN_W-1:0] ch_gain [DAV_CHANNELS]; // per-channel gain
   logic signed [DAV_RESULT_W-1:0] ch_result [DAV_CHANNELS]; // per-channel output
   logic [DAV_CHANNELS-1:0] ch_done; // per-channel update pulse

   // channels 0..2 carry angle, 3..5 carry speed, x first
   assign ch_sample[0] = gyro_in.x;
   assign ch_sample[1] = gyro_in.y;
   assign ch_sample[2] = gyro_in.z;
   assign ch_sample[3] = accel_in.x;
   assign ch_sample[4] = accel_in.y;
   assign ch_sample[5] = accel_in.z;

   genvar ch;
   generate
      for (ch = 0; ch < DAV_CHANNELS; ch++) begin : g_chan
         // speed gain is fixed by the +-100 m/s span
         assign ch_gain[ch] = (ch < DAV_AXES) ? angle_gain : DAV_GAIN_SPEED;

         // every channel sees the same tick and interval, so all finish together
         dav_integ u_integ (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .sample_valid_in(sample_tick),
            .first_in(interval_first),
            .last_in(interval_last),
            .sample_in(ch_sample[ch]),
            .gain_in(ch_gain[ch]),
            .result_out(ch_result[ch]),
            .done_out(ch_done[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // frame assembly and buffering
   // ----------------------------------------------------------------
   dav_frame_t new_frame; // all six results of one interval
   dav_frame_t shown_frame_next; // head of the buffer
   logic frame_valid; // buffer has a frame waiting
   logic frame_take; // output registers accept it
   logic read_lock; // host is between the two words of a pair

   always_comb begin
      new_frame.angle.x = ch_result[0];
      new_frame.angle.y = ch_result[1];
      new_frame.angle.z = ch_result[2];
      new_frame.speed.x = ch_result[3];
      new_frame.speed.y = ch_result[4];
      new_frame.speed.z = ch_result[5];
   end

   // a full buffer drops the newest frame; result_room_out shows when that
   // would happen, trading an occasional lost update for a coherent pair
   dav_buf2 #(
      .WIDTH($bits(dav_frame_t))
   ) u_buf (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(ch_done[0]),
      .in_ready_out(result_room_out),
      .in_data_in(new_frame),
      .out_valid_out(frame_valid),
      .out_ready_in(~read_lock),
      .out_data_out(shown_frame_next)
   );

   assign frame_take = frame_valid && !read_lock;

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   dav_frame_t shown; // what the host reads

   // all twelve words load together from one interval
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shown <= '0;
      end else if (frame_take) begin
         shown <= shown_frame_next;
      end
   end

   // update pulse follows each load of the output registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         update_out <= 1'b0;
      end else begin
         update_out <= frame_take;
      end
   end

   // ----------------------------------------------------------------
   // read lock
   // ----------------------------------------------------------------
   logic rd_low; // read hits a low word
   logic rd_high; // read hits a high word

   always_comb begin
      rd_low = 1'b0;
      rd_high = 1'b0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            DAV_X_ANGLE_STEP_LOW, DAV_Y_ANGLE_STEP_LOW, DAV_Z_ANGLE_STEP_LOW,
            DAV_X_SPEED_STEP_LOW, DAV_Y_SPEED_STEP_LOW, DAV_Z_SPEED_STEP_LOW: begin
               rd_low = 1'b1;
            end
            DAV_X_ANGLE_STEP_HIGH, DAV_Y_ANGLE_STEP_HIGH, DAV_Z_ANGLE_STEP_HIGH,
            DAV_X_SPEED_STEP_HIGH, DAV_Y_SPEED_STEP_HIGH, DAV_Z_SPEED_STEP_HIGH: begin
               rd_high = 1'b1;
            end
            default: begin
               rd_low = 1'b0;
            end
         endcase
      end
   end

   // a low-word read freezes the outputs until a high word is read; a frame that loads in
   // the low read's own cycle still splits the pair, and a host that never reads high stalls it
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         read_lock <= 1'b0;
      end else if (rd_high) begin
         read_lock <= 1'b0;
      end else if (rd_low) begin
         read_lock <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   logic [DAV_WORD_W-1:0] next_read; // decoded word

   // high word is bits 31:16 of the two's complement result, low 15:0
   always_comb begin
      unique case (reg_addr_in)
         DAV_X_ANGLE_STEP_LOW: next_read = shown.angle.x[DAV_WORD_W-1:0];
         DAV_X_ANGLE_STEP_HIGH: next_read = shown.angle.x[DAV_RESULT_W-1:DAV_WORD_W];
         DAV_Y_ANGLE_STEP_LOW: next_read = shown.angle.y[DAV_WORD_W-1:0];
         DAV_Y_ANGLE_STEP_HIGH: next_read = shown.angle.y[DAV_RESULT_W-1:DAV_WORD_W];
         DAV_Z_ANGLE_STEP_LOW: next_read = shown.angle.z[DAV_WORD_W-1:0];
         DAV_Z_ANGLE_STEP_HIGH: next_read = shown.angle.z[DAV_RESULT_W-1:DAV_WORD_W];
         DAV_X_SPEED_STEP_LOW: next_read = shown.speed.x[DAV_WORD_W-1:0];
         DAV_X_SPEED_STEP_HIGH: next_read = shown.speed.x[DAV_RESULT_W-1:DAV_WORD_W];
         DAV_Y_SPEED_STEP_LOW: next_read = shown.speed.y[DAV_WORD_W-1:0];
         DAV_Y_SPEED_STEP_HIGH: next_read = shown.speed.y[DAV_RESULT_W-1:DAV_WORD_W];
         DAV_Z_SPEED_STEP_LOW: next_read = shown.speed.z[DAV_WORD_W-1:0];
         DAV_Z_SPEED_STEP_HIGH: next_read = shown.speed.z[DAV_RESULT_W-1:DAV_WORD_W];
         default: next_read = DAV_UNMAPPED; // unmapped reads as zero
      endcase
   end

   // read data is held until the next read; ack marks the new word
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reg_data_out <= '0;
         reg_ack_out <= 1'b0;
      end else begin
         reg_ack_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_data_out <= next_read;
         end
      end
   end

endmodule : dav_outputs

//--- test/dav_outputs_assertions.sv
module dav_outputs_assertions #(
   parameter int SAMPLE_CYCLES = dav_pkg::DAV_SAMPLE_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic reg_rd_in,
   input wire logic [dav_pkg::DAV_ADDR_W-1:0] reg_addr_in,
   input wire logic [dav_pkg::DAV_WORD_W-1:0] reg_data_out,
   input wire logic reg_ack_out,
   input wire logic sample_tick_out,
   input wire logic update_out,
   input wire logic result_room_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import dav_pkg::*;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   int gap; // cycles since the last tick
   logic seen; // first tick has no predecessor to measure from
   logic mapped; // even offsets of the twelve result registers
   assign mapped = (reg_addr_in inside {[7'h24:7'h3A]}) && !reg_addr_in[0];
   // tick spacing counter
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (sample_tick_out) begin
         gap <= 0;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end
   a_ack_after_read: assert property (reg_rd_in |=> reg_ack_out) else $error("read got no ack");
   a_ack_has_cause: assert property (reg_ack_out |-> $past(reg_rd_in)) else $error("ack without read");
   a_ack_one_cycle: assert property (reg_ack_out && !reg_rd_in |=> !reg_ack_out) else $error("ack too long");
   a_data_holds: assert property (!$past(reg_rd_in) |-> $stable(reg_data_out)) else $error("data moved");
   a_unmapped_zero: assert property (reg_rd_in && !mapped |=> reg_data_out == 16'h0000)
      else $error("unmapped read not zero");
   a_tick_spacing: assert property (sample_tick_out && seen |-> gap == SAMPLE_CYCLES - 1)
      else $error("tick spacing wrong");
   // a frame held by the read lock loads the cycle the high-word ack shows, so its update
   // trails that ack by one cycle; a second buffered frame follows the first back to back
   a_update_cause: assert property (update_out |-> $past(sample_tick_out, 2) || $past(reg_ack_out)
      || $past(update_out)) else $error("update without cause");
   a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !reg_ack_out && !update_out
      && !sample_tick_out && result_room_out && reg_data_out == 16'h0000) else $error("reset state wrong");
   c_update: cover property (update_out);
   c_full: cover property (!result_room_out);
   c_negative: cover property (reg_ack_out && reg_data_out[15]);
endmodule : dav_outputs_assertions

bind dav_outputs dav_outputs_assertions #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (.clk_in, .rst_in, .reg_rd_in,
   .reg_addr_in, .reg_data_out, .reg_ack_out, .sample_tick_out, .update_out, .result_room_out);

//--- test/dav_host_model.sv
module dav_host_model (
   input wire logic clk_in,
   output logic reg_rd_out,
   output logic [dav_pkg::DAV_ADDR_W-1:0] reg_addr_out,
   input wire logic [dav_pkg::DAV_WORD_W-1:0] reg_data_in,
   input wire logic reg_ack_in
);
   timeunit 1ns;
   timeprecision 1ns;
   import dav_pkg::*;
   // ----------------------------------------------------------------
   // host reader: one strobe per read, waits a few cycles for ack
   // ----------------------------------------------------------------
   initial begin
      reg_rd_out = 1'b0;
      reg_addr_out = 7'h00;
   end
   task automatic read(input logic [DAV_ADDR_W-1:0] a, output logic [DAV_WORD_W-1:0] d, output bit ok);
      ok = 1'b0;
      d = 16'h0000;
      @(posedge clk_in);
      #1;
      reg_rd_out = 1'b1;
      reg_addr_out = a;
      @(posedge clk_in);
      #1;
      // strobe is one cycle; idle address flipped so a stale value is never reused
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_ack_in === 1'b1) begin
            d = reg_data_in;
            ok = 1'b1;
         end else begin
            @(posedge clk_in);
            #1;
         end
      end
   endtask : read
endmodule : dav_host_model

//--- test/dav_outputs_tb.sv
module dav_outputs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dav_pkg::*;
   // ----------------------------------------------------------------
   // bench signals
   // ----------------------------------------------------------------
   localparam int SC = 8; // short sample period keeps the run small
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   dav_sensor_t gyro = '0;
   dav_sensor_t accel = '0;
   logic [1:0] rng = 2'h0;
   logic [DAV_DEC_W-1:0] dec = 16'h0000;
   logic rd;
   logic [DAV_ADDR_W-1:0] addr;
   logic [DAV_WORD_W-1:0] data;
   logic ack, tick, upd, room;
   int bad_count = 0;
   int compares = 0;
   int gap;
   always #50 clk_in = ~clk_in;
   dav_outputs #(.SAMPLE_CYCLES(SC)) u_dut (.clk_in, .rst_in, .gyro_in(gyro), .accel_in(accel),
      .gyro_range_in(rng), .decimation_setting_in(dec), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_data_out(data), .reg_ack_out(ack), .sample_tick_out(tick), .update_out(upd), .result_room_out(room));
   dav_host_model u_host (.clk_in, .reg_rd_out(rd), .reg_addr_out(addr), .reg_data_in(data), .reg_ack_in(ack));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   // a read that never acks ends the run
   task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
      logic [15:0] d;
      bit ok;
      u_host.read(a, d, ok);
      if (!ok) begin
         bad_count++;
         conclude();
      end
      check({16'h0000, d}, {16'h0000, exp}, "register");
   endtask : rd_chk
   task automatic wait_upd(input int n);
      for (int k = 0; k < n; k++) begin
         gap = 0;
         do begin
            @(posedge clk_in);
            #1;
            gap++;
            if (gap > 4000) begin
               bad_count++;
               conclude();
            end
         end while (upd !== 1'b1);
      end
   endtask : wait_upd
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_reset();
      check({31'h0, room}, 32'h1, "room");
      for (int i = 0; i < 12; i++) begin
         rd_chk(7'h24 + 7'(2 * i), 16'h0000);
      end
      rd_chk(7'h40, 16'h0000);
      rd_chk(7'h20, 16'h0000);
   endtask : s_reset
   // every axis of both kinds, high and low words of one result
   task automatic s_axes();
      logic [31:0] exp [6] = '{32'h00000100, 32'h00000200, 32'hFFFFFF00, 32'h00000080, 32'hFFFFFE00, 32'h00000002};
      gyro = '{16'h0800, 16'h1000, 16'hF800};
      accel = '{16'h0400, 16'hF000, 16'h0010};
      wait_upd(3);
      for (int i = 0; i < 6; i++) begin
         rd_chk(7'h24 + 7'(4 * i), exp[i][15:0]);
         rd_chk(7'h26 + 7'(4 * i), exp[i][31:16]);
      end
   endtask : s_axes
   // each range code scales the same negative rate
   task automatic s_ranges();
      logic [31:0] exp [4] = '{32'hFFFFFF00, 32'hFFFFFF80, 32'hFFFFFFD5, 32'hFFFFFF00};
      gyro.x = 16'hF800;
      for (int r = 0; r < 4; r++) begin
         rng = 2'(r);
         // a frame held by the last read's lock can load first, and the next one
         // pairs the new rate with the old predecessor, so the third is settled
         wait_upd(3);
         rd_chk(7'h24, exp[r][15:0]);
         rd_chk(7'h26, exp[r][31:16]);
      end
      rng = 2'h0;
   endtask : s_ranges
   // four samples per interval, spacing follows the setting
   task automatic s_decim();
      // host-side rate measurement: with the setting at zero, updates come once per sample
      wait_upd(3);
      check(32'(gap), 32'(SC), "ready spacing");
      dec = 16'h0003;
      accel.x = 16'h03E8;
      wait_upd(3);
      check(32'(gap), 32'((dec + 1) * SC), "interval");
      rd_chk(7'h30, 16'h01F4);
      rd_chk(7'h32, 16'h0000);
      dec = 16'h0000;
   endtask : s_decim
   // a held low word freezes its partner while the buffer fills
   task automatic s_lock();
      int n;
      wait_upd(2);
      rd_chk(7'h28, 16'h0200);
      gyro.y = 16'hF800;
      for (n = 0; room === 1'b1 && n < 200; n++) begin
         @(posedge clk_in);
         #1;
      end
      check({31'h0, room}, 32'h0, "room full");
      rd_chk(7'h2A, 16'h0000);
      wait_upd(3);
      check({31'h0, room}, 32'h1, "room back");
      rd_chk(7'h28, 16'hFF00);
      rd_chk(7'h2A, 16'hFFFF);
   endtask : s_lock
   // main sequence
   initial begin
      repeat (6) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      s_reset();
      s_axes();
      s_ranges();
      s_decim();
      s_lock();
      conclude();
   end
endmodule : dav_outputs_tb
